//--- design/icc_pkg.sv
// constants and carrier types for the input conditioning block
package icc_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_IN = 16;
   localparam int NUM_CAP = 8;
   localparam int NUM_CMP = 8;
   localparam int NUM_OUT = 8;
   localparam int FT_W = 25;

   // ----------------------------------------------------------------
   // timing: filter unit and clock period, in ps
   // ----------------------------------------------------------------
   localparam int FILT_UNIT_PS = 10000;   // 0.01 us
   localparam int CLK_PERIOD_PS = 4000;   // 250 MHz
   localparam logic [15:0] TICK_STEP = 16'(CLK_PERIOD_PS);
   localparam logic [15:0] TICK_WRAP = 16'(FILT_UNIT_PS);

   // ----------------------------------------------------------------
   // filter time range and reset value, in filter units
   // ----------------------------------------------------------------
   localparam logic [FT_W-1:0] FT_MAX = 25'h1C9_C380;  // 30,000,000
   localparam logic [FT_W-1:0] FT_RESET = 25'h0064;    // 100 = 1 us

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_LEVEL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_IEN = 8'h0C;
   localparam logic [7:0] REG_POL = 8'h10;
   localparam logic [7:0] REG_EDGE = 8'h14;
   localparam logic [7:0] REG_CAP_EN = 8'h18;
   localparam logic [7:0] REG_CAP_SRC = 8'h1C;
   localparam logic [7:0] REG_CMP_EN = 8'h20;
   localparam logic [7:0] REG_CMP_SEL = 8'h24;
   localparam logic [1:0] REG_FT_BLK = 2'h1;     // 0x40..0x7C
   localparam logic [2:0] REG_CAPV_BLK = 3'h4;   // 0x80..0x9C
   localparam logic [2:0] REG_CMPV_BLK = 3'h5;   // 0xA0..0xBC

   // ----------------------------------------------------------------
   // status field positions and reset values
   // ----------------------------------------------------------------
   localparam int ST_IN_LSB = 0;
   localparam int ST_CAP_LSB = 16;
   localparam int ST_CMP_LSB = 24;
   localparam logic [31:0] EDGE_RESET = 32'h5555_5555;  // all rising

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH
   } icc_edge_t;

   typedef enum logic {BUS_IDLE, BUS_ACK} icc_bus_st_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } icc_av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } icc_av_rsp_t;

endpackage

//--- design/icc_top.sv
// input conditioning, capture and compare front end with avalon slave
//
// What this block does
// - eight capture and eight compare channels, each with its own enable
// - capture trigger comes from an input picked per channel
// - compare result drives an output contact picked per channel
// - per-input interrupt enable, off at reset, edge select rise/fall/both
// - filter time per input in 0.01 us units, range 0 to 30,000,000
// - filter time of each input is 100 units after reset
// - polarity defaults to normally open, no inversion
// - normally closed polarity inverts input before filter and edges
`timescale 1ns/100ps

module icc_top
   import icc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // register bus
   input wire icc_av_req_t av_req,
   output icc_av_rsp_t av_rsp,
   // field side
   input wire logic [NUM_IN-1:0] din,
   output logic [NUM_OUT-1:0] dout,
   // counter core value
   input wire logic [31:0] count_value,
   // interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   icc_bus_st_t bus_st;
   logic wr_en;
   logic [31:0] next_rdata, stat, mask, edge_sel, cap_src, cmp_sel;
   logic [NUM_IN-1:0] ien, pol, filt, filt_d, rise, fall, in_evt;
   logic [NUM_CAP-1:0] cap_en, cap_evt;
   logic [NUM_CMP-1:0] cmp_en, cmp_hit, cmp_hit_d, cmp_evt;
   logic [FT_W-1:0] ftime [NUM_IN];
   logic [31:0] cap_val [NUM_CAP];
   logic [31:0] cmp_val [NUM_CMP];
   logic [NUM_OUT-1:0] next_dout;
   logic [31:0] evt;
   logic [15:0] tick_acc;
   logic tick;

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // avalon slave
   // ----------------------------------------------------------------

   // one wait cycle, then a one-cycle answer with waitrequest low
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_st <= BUS_IDLE;
         av_rsp.waitrequest <= 1'b1;
         av_rsp.readdata <= 32'h0000_0000;
      end else if (bus_st == BUS_IDLE &&
                   (av_req.read || av_req.write)) begin
         bus_st <= BUS_ACK;
         av_rsp.waitrequest <= 1'b0;
         av_rsp.readdata <= av_req.read ? next_rdata : 32'h0000_0000;
      end else begin
         bus_st <= BUS_IDLE;
         av_rsp.waitrequest <= 1'b1;
      end
   end

   // writes land on the edge that sees waitrequest low
   assign wr_en = av_req.write && bus_st == BUS_ACK;

   // read mux, unmapped reads as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (av_req.address == REG_LEVEL) begin
         next_rdata = {16'h0000, filt};
      end else if (av_req.address == REG_STAT) begin
         next_rdata = stat;
      end else if (av_req.address == REG_MASK) begin
         next_rdata = mask;
      end else if (av_req.address == REG_IEN) begin
         next_rdata = {16'h0000, ien};
      end else if (av_req.address == REG_POL) begin
         next_rdata = {16'h0000, pol};
      end else if (av_req.address == REG_EDGE) begin
         next_rdata = edge_sel;
      end else if (av_req.address == REG_CAP_EN) begin
         next_rdata = {24'h00_0000, cap_en};
      end else if (av_req.address == REG_CAP_SRC) begin
         next_rdata = cap_src;
      end else if (av_req.address == REG_CMP_EN) begin
         next_rdata = {24'h00_0000, cmp_en};
      end else if (av_req.address == REG_CMP_SEL) begin
         next_rdata = cmp_sel;
      end else if (av_req.address[7:6] == REG_FT_BLK) begin
         next_rdata = {7'h00, ftime[av_req.address[5:2]]};
      end else if (av_req.address[7:5] == REG_CAPV_BLK) begin
         next_rdata = cap_val[av_req.address[4:2]];
      end else if (av_req.address[7:5] == REG_CMPV_BLK) begin
         next_rdata = cmp_val[av_req.address[4:2]];
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------

   // plain read-write control bits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mask <= 32'h0000_0000;
         ien <= 16'h0000;
         pol <= 16'h0000;                // normally open
         edge_sel <= EDGE_RESET;
         cap_en <= 8'h00;
         cap_src <= 32'h0000_0000;
         cmp_en <= 8'h00;
         cmp_sel <= 32'h0000_0000;
      end else if (wr_en) begin
         if (av_req.address == REG_MASK) begin
            mask <= av_req.writedata;
         end else if (av_req.address == REG_IEN) begin
            ien <= av_req.writedata[15:0];
         end else if (av_req.address == REG_POL) begin
            pol <= av_req.writedata[15:0];
         end else if (av_req.address == REG_EDGE) begin
            edge_sel <= av_req.writedata;
         end else if (av_req.address == REG_CAP_EN) begin
            cap_en <= av_req.writedata[7:0];
         end else if (av_req.address == REG_CAP_SRC) begin
            cap_src <= av_req.writedata;
         end else if (av_req.address == REG_CMP_EN) begin
            cmp_en <= av_req.writedata[7:0];
         end else if (av_req.address == REG_CMP_SEL) begin
            cmp_sel <= av_req.writedata;
         end
      end
   end

   // ----------------------------------------------------------------
   // filter time base
   // ----------------------------------------------------------------

   // phase accumulator: one tick per 0.01 us on average
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tick_acc <= 16'h0000;
         tick <= 1'b0;
      end else if (tick_acc + TICK_STEP >= TICK_WRAP) begin
         tick_acc <= 16'(tick_acc + TICK_STEP - TICK_WRAP);
         tick <= 1'b1;
      end else begin
         tick_acc <= 16'(tick_acc + TICK_STEP);
         tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // per-input polarity, filter and edge events
   // ----------------------------------------------------------------
   for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic [FT_W-1:0] fcnt;
      logic lvl;
      icc_edge_t esel;

      // normally closed contact inverted ahead of everything
      assign lvl = din[gi] ^ pol[gi];
      assign esel = icc_edge_t'(edge_sel[2*gi +: 2]);

      // filter time register, out-of-range writes clamp to max
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            ftime[gi] <= FT_RESET;
         end else if (wr_en && av_req.address[7:6] == REG_FT_BLK &&
                      av_req.address[5:2] == 4'(gi)) begin
            if (av_req.writedata > {7'h00, FT_MAX}) begin
               ftime[gi] <= FT_MAX;
            end else begin
               ftime[gi] <= av_req.writedata[FT_W-1:0];
            end
         end
      end

      // debounce: change only after a full stable period
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            filt[gi] <= 1'b0;
            fcnt <= '0;
         end else if (ftime[gi] == '0) begin
            filt[gi] <= lvl;
            fcnt <= '0;
         end else if (lvl == filt[gi]) begin
            fcnt <= '0;  // bounce restarts the wait
         end else if (fcnt >= ftime[gi]) begin
            filt[gi] <= lvl;
            fcnt <= '0;
         end else if (tick) begin
            fcnt <= FT_W'(fcnt + 1'b1);
         end
      end

      // edge detect and interrupt qualification
      assign rise[gi] = filt[gi] & ~filt_d[gi];
      assign fall[gi] = ~filt[gi] & filt_d[gi];
      assign in_evt[gi] = ien[gi] &
         ((rise[gi] & (esel == EDGE_RISE || esel == EDGE_BOTH)) |
          (fall[gi] & (esel == EDGE_FALL || esel == EDGE_BOTH)));
   end

   // delayed filtered levels
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         filt_d <= 16'h0000;
      end else begin
         filt_d <= filt;
      end
   end

   // ----------------------------------------------------------------
   // capture channels
   // ----------------------------------------------------------------
   for (genvar gc = 0; gc < NUM_CAP; gc++) begin : g_cap
      // rising filtered edge of the selected input triggers
      assign cap_evt[gc] = cap_en[gc] &
         rise[cap_src[4*gc +: 4]];

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            cap_val[gc] <= 32'h0000_0000;
         end else if (cap_evt[gc]) begin
            cap_val[gc] <= count_value;
         end
      end
   end

   // ----------------------------------------------------------------
   // compare channels
   // ----------------------------------------------------------------
   for (genvar gk = 0; gk < NUM_CMP; gk++) begin : g_cmp
      assign cmp_hit[gk] = cmp_en[gk] &&
         count_value >= cmp_val[gk];
      assign cmp_evt[gk] = cmp_hit[gk] & ~cmp_hit_d[gk];

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            cmp_val[gk] <= 32'h0000_0000;
         end else if (wr_en && av_req.address[7:5] == REG_CMPV_BLK &&
                      av_req.address[4:2] == 3'(gk)) begin
            cmp_val[gk] <= av_req.writedata;
         end
      end
   end

   // route each active compare to its selected contact
   always_comb begin
      next_dout = '0;
      for (int k = 0; k < NUM_CMP; k++) begin
         if (cmp_hit[k]) begin
            next_dout[cmp_sel[4*k +: 3]] = 1'b1;
         end
      end
   end

   // registered outputs and compare history
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dout <= 8'h00;
         cmp_hit_d <= 8'h00;
      end else begin
         dout <= next_dout;
         cmp_hit_d <= cmp_hit;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, write one to clear, set wins
   // ----------------------------------------------------------------
   assign evt = {cmp_evt, cap_evt, in_evt};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stat <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         if (wr_en && av_req.address == REG_STAT) begin
            stat <= (stat & ~av_req.writedata) | evt;
         end else begin
            stat <= stat | evt;
         end
         irq <= |(stat & mask);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_cap_trig;
      cap_en[1] && rise[cap_src[7:4]];
   endsequence

   sequence s_nc_direct;
      (ftime[2] == '0 && pol[2])[*2];
   endsequence

   cap_gate_a: assert property (!cap_en[0] |=> $stable(cap_val[0]))
      else $error("capture value moved on disabled channel");
   cap_latch_a: assert property (s_cap_trig |=>
      cap_val[1] == $past(count_value) && stat[ST_CAP_LSB+1])
      else $error("capture did not latch counter");
   cmp_route_a: assert property (cmp_hit[2] && cmp_sel[10:8] == 3'h6
      |=> dout[6])
      else $error("compare result not on selected output");
   edge_rise_a: assert property (
      rise[0] && ien[0] && edge_sel[1:0] == EDGE_RISE |=> stat[0])
      else $error("rising edge did not set status");
   irq_off_a: assert property ((!ien[0] && !stat[0]) |=> !stat[0])
      else $error("status set with interrupt disabled");
   ft_range_a: assert property (ftime[7] <= FT_MAX)
      else $error("filter time out of range");
   tick_rate_a: assert property (tick |=> !tick)
      else $error("filter tick too fast");
   nc_invert_a: assert property (
      s_nc_direct |=> filt[2] == !$past(din[2]))
      else $error("normally closed input not inverted");
   filt_hold_a: assert property (
      (ftime[1] >= 25'h0004 && $past(ftime[1]) >= 25'h0004 &&
       $changed(filt[1])) |=> $stable(filt[1])[*8])
      else $error("filter passed a level too soon");
   irq_level_a: assert property (((stat & mask) != '0)[*2] |-> irq)
      else $error("interrupt low with unmasked status");

endmodule

//--- sim/icc_field.sv
// field contact model: switches that settle on command or chatter
`timescale 1ns/100ps

module icc_field
   import icc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // commanded contact state
   input wire logic [NUM_IN-1:0] target,
   input wire logic [NUM_IN-1:0] chatter,
   // contacts toward the block
   output logic [NUM_IN-1:0] din
);

   // chattering contacts flip every cycle, the others follow target
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         din <= '0;
      end else begin
         din <= (target & ~chatter) | (~din & chatter);
      end
   end

endmodule

//--- sim/test_input_conditioning_capture_compare.sv
// self-checking bench for the input conditioning front end
`timescale 1ns/100ps

module test_input_conditioning_capture_compare
   import icc_pkg::*;
;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic core_clk;
   logic rstn;
   icc_av_req_t req;
   icc_av_rsp_t rsp;
   logic [NUM_IN-1:0] din;
   logic [NUM_IN-1:0] target;
   logic [NUM_IN-1:0] chatter;
   logic [NUM_OUT-1:0] dout;
   logic [31:0] count_value;
   logic irq;
   logic [31:0] rd;
   int n_fail = 0;
   int cmp_count = 0;
   // reset table: addresses and their values, 0x30 is a hole
   logic [7:0] ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
      8'h18, 8'h1C, 8'h20, 8'h24, 8'h40, 8'h7C, 8'hA0, 8'h30};
   logic [31:0] rv [14] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      EDGE_RESET, 32'h0, 32'h0, 32'h0, 32'h0, 32'h64, 32'h64, 32'h0,
      32'h0};

   // 250 MHz clock
   always #2 core_clk = ~core_clk;

   icc_top DUT (.core_clk(core_clk), .rstn(rstn), .av_req(req),
      .av_rsp(rsp), .din(din), .dout(dout), .count_value(count_value),
      .irq(irq));

   icc_field field (.core_clk(core_clk), .rstn(rstn), .target(target),
      .chatter(chatter), .din(din));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // one access, held until waitrequest is sampled low
   task automatic acc(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      req.read <= ~wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= wd;
      do @(posedge core_clk); while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask

   task automatic rc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      acc(1'b0, a, '0);
      chk(nm, e, rd);
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      req = '0;
      count_value = 32'h0;
      target = '0;
      chatter = '0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      // reset values and an unmapped hole
      for (int i = 0; i < 14; i++) begin
         rc("reset", ra[i], rv[i]);
      end
      // dropped write to a hole, clamped filter time
      wr(8'h30, 32'hFFFF_FFFF);
      rc("hole", 8'h30, 32'h0);
      wr(8'h5C, 32'h0200_0000);
      rc("ft clamp", 8'h5C, {7'h0, FT_MAX});
      wr(8'h40, 32'h0);
      wr(8'h48, 32'h0);
      wr(8'h4C, 32'h0);
      wr(8'h54, 32'h0);
      rc("ft zero", 8'h40, 32'h0);
      wr(8'h44, 32'h0000_000A);
      // chatter never settles, then a clean step on inputs 1 and 4
      chatter <= 16'h0002;
      cyc(60);
      rc("chatter", REG_LEVEL, 32'h0);
      chatter <= 16'h0;
      target <= 16'h0012;
      cyc(16);
      rc("early", REG_LEVEL, 32'h0);
      cyc(20);
      rc("ft 10", REG_LEVEL, 32'h0002);
      cyc(235);
      rc("ft reset", REG_LEVEL, 32'h0012);
      // normally closed input 2 reads high, no event without enable
      wr(REG_POL, 32'h0004);
      cyc(4);
      rc("nc level", REG_LEVEL, 32'h0016);
      rc("no ien", REG_STAT, 32'h0);
      // every edge mode on input 0
      wr(REG_IEN, 32'h0001);
      wr(REG_MASK, 32'h0001);
      for (int m = 0; m < 4; m++) begin
         wr(REG_EDGE, {EDGE_RESET[31:2], 2'(m)});
         wr(REG_STAT, 32'hFFFF_FFFF);
         target[0] <= 1'b1;
         cyc(6);
         rc("rise", REG_STAT, {31'h0, m[0]});
         chk("irq", {31'h0, m[0]}, {31'h0, irq});
         wr(REG_STAT, 32'h0001);
         target[0] <= 1'b0;
         cyc(6);
         rc("fall", REG_STAT, {31'h0, m[1]});
      end
      // masked event keeps irq low
      wr(REG_STAT, 32'hFFFF_FFFF);
      wr(REG_MASK, 32'h0);
      target[0] <= 1'b1;
      cyc(6);
      chk("masked", 32'h0, {31'h0, irq});
      // capture on input 5 only, channel 0 left off
      wr(REG_STAT, 32'hFFFF_FFFF);
      wr(REG_CAP_SRC, 32'h0000_0055);
      wr(REG_CAP_EN, 32'h0002);
      count_value <= 32'h0000_1111;
      target[3] <= 1'b1;
      cyc(8);
      count_value <= 32'h1234_5678;
      target[5] <= 1'b1;
      cyc(8);
      count_value <= 32'h0000_00FF;
      rc("cap val", 8'h84, 32'h1234_5678);
      rc("cap off", 8'h80, 32'h0);
      rc("cap stat", REG_STAT, 32'h0002_0000);
      // compare 2 steers output 6, disabled 3 on output 7
      wr(REG_STAT, 32'hFFFF_FFFF);
      wr(8'hA8, 32'h0000_0100);
      wr(REG_CMP_SEL, 32'h0000_7600);
      wr(REG_CMP_EN, 32'h0004);
      cyc(4);
      chk("below", 32'h0, {24'h0, dout});
      count_value <= 32'h0000_0100;
      cyc(4);
      chk("hit", 32'h0000_0040, {24'h0, dout});
      rc("cmp stat", REG_STAT, 32'h0400_0000);
      end_of_test();
   end

   // watchdog: the sequence needs well under 2,000 cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      end_of_test();
   end

endmodule
